// >>> ccpt_pkg.sv
// shared constants and types for the compare tail and pwm channel
package ccpt_pkg;

  // ---------------------------------------------------------------
  // register map (word index on the avalon address)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W      = 3;
  localparam logic [2:0] REG_CTRL     = 3'h0;
  localparam logic [2:0] REG_DUTY     = 3'h1;
  localparam logic [2:0] REG_PLIMIT   = 3'h2;
  localparam logic [2:0] REG_TCTRL    = 3'h3;
  localparam logic [2:0] REG_STATUS   = 3'h4;
  localparam logic [2:0] REG_IENABLE  = 3'h5;
  localparam logic [2:0] REG_COUNTER  = 3'h6;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT   = 7;
  localparam int unsigned CTRL_OUT_BIT  = 5;
  localparam int unsigned CTRL_LEFT_BIT = 4;
  localparam int unsigned TCTRL_ON_BIT  = 0;
  localparam int unsigned TCTRL_PS_LSB  = 1;
  localparam int unsigned STAT_EVT_BIT  = 0;
  localparam int unsigned STAT_TMR_BIT  = 1;
  localparam int unsigned IE_CMP_BIT    = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [15:0] DUTY_RST   = 16'h0000;
  localparam logic [7:0]  PLIMIT_RST = 8'hFF;
  localparam logic [2:0]  TCTRL_RST  = 3'h0;

  // ---------------------------------------------------------------
  // timing: instruction clock is the system clock divided by four
  // ---------------------------------------------------------------
  localparam int unsigned INSTR_DIV  = 4;

  // ---------------------------------------------------------------
  // mode field codes
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_OFF       = 4'h0;
  localparam logic [3:0] MODE_TOG_CLR   = 4'h1;
  localparam logic [3:0] MODE_TOG       = 4'h2;
  localparam logic [3:0] MODE_SET       = 4'h8;
  localparam logic [3:0] MODE_CLR       = 4'h9;
  localparam logic [3:0] MODE_PULSE     = 4'hA;
  localparam logic [3:0] MODE_PULSE_CLR = 4'hB;

  typedef enum logic [1:0] {OP_OFF, OP_CAPTURE, OP_COMPARE, OP_PWM}
    ccpt_op_t;

  function automatic ccpt_op_t ccpt_op_of(input logic [3:0] mode);
    ccpt_op_t op;
    op = OP_OFF;
    case (mode)
      MODE_OFF:                         op = OP_OFF;
      MODE_TOG_CLR, MODE_TOG,
      MODE_SET, MODE_CLR,
      MODE_PULSE, MODE_PULSE_CLR:       op = OP_COMPARE;
      4'hC, 4'hD, 4'hE, 4'hF:           op = OP_PWM;
      default:                          op = OP_CAPTURE;
    endcase
    return op;
  endfunction

endpackage

// >>> ccpt_prescale.sv
// system clock phase, instruction enable and period timer prescaler
`timescale 1ns/1ps
`default_nettype none
module ccpt_prescale
  import ccpt_pkg::*;
(
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  // control
  input  wire logic       i_run,
  input  wire logic [1:0] i_ps_sel,
  // time base
  output logic            o_tick,
  output logic [1:0]      o_ext
);

  logic [1:0] ph_q;
  logic [5:0] pre_q;
  logic [5:0] pre_top;
  logic       instr_en;
  logic       pre_wrap;

  // ---------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------
  assign instr_en = (ph_q == 2'(INSTR_DIV - 1));
  assign pre_top  = (i_ps_sel == 2'h0) ? 6'h00 :
                    (i_ps_sel == 2'h1) ? 6'h03 :
                    (i_ps_sel == 2'h2) ? 6'h0F : 6'h3F;
  // a count past the top wraps at once, so a smaller prescale applies
  assign pre_wrap = (pre_q >= pre_top);
  assign o_tick   = i_run && instr_en && pre_wrap;
  // low bits come from clock phase at 1:1, else from prescaler
  assign o_ext    = (i_ps_sel == 2'h0) ? ph_q :
                    (i_ps_sel == 2'h1) ? pre_q[1:0] :
                    (i_ps_sel == 2'h2) ? pre_q[3:2] : pre_q[5:4];

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      ph_q  <= 2'h0;
      pre_q <= 6'h00;
    end
    else if (i_run)
    begin
      ph_q <= ph_q + 2'h1;
      if (instr_en)
        pre_q <= pre_wrap ? 6'h00 : pre_q + 6'h01;
    end
  end

endmodule
`default_nettype wire

// >>> ccpt_compare.sv
// compare match event, conversion trigger and timer clear
`timescale 1ns/1ps
`default_nettype none
module ccpt_compare
  import ccpt_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  // control
  input  wire logic        i_enable,
  input  wire logic        i_clears_timer,
  input  wire logic        i_trig_sel,
  input  wire logic [15:0] i_timer,
  input  wire logic [15:0] i_value,
  // results
  output logic             o_evt,
  output logic             o_adc_trig,
  output logic             o_timer_clr
);

  logic match;
  logic match_q;
  logic pend_q;

  assign match = i_enable && (i_timer == i_value);
  assign o_evt = match && !match_q;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      match_q     <= 1'b0;
      pend_q      <= 1'b0;
      o_adc_trig  <= 1'b0;
      o_timer_clr <= 1'b0;
    end
    else
    begin
      match_q     <= match;
      o_adc_trig  <= o_evt && i_trig_sel;
      pend_q      <= o_evt && i_clears_timer;
      // reset only if the match still holds one edge later
      o_timer_clr <= pend_q && match;
    end
  end

  a_trig_on_match: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    o_evt && i_trig_sel |=> o_adc_trig)
    else $error("trigger missing after compare match");

  a_clr_withdrawn: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    pend_q && !match |=> !o_timer_clr)
    else $error("timer reset despite removed match");

endmodule
`default_nettype wire

// >>> ccpt_channel.sv
// compare output tail and ten-bit pwm channel with avalon registers
//
// Notes on behaviour
// - writing zero to control forces the compare output latch low
// - compare and pwm modes set event flag; compare match may fire conversion trigger
// - removed match between trigger and reset edge cancels timer reset
// - sleep compare works only with running timer; enabled event wakes
// - channel output also offered to other on-chip peripherals
// - period is (limit+1) times four clocks times prescale
// - after limit match: clear timer, load duty buffer, then set output unless buffer is zero
// - timer postscaler never affects pwm period
// - duty register writable anytime; used only after period match
// - ten-bit duty taken from register by alignment bit
// - time base is timer plus two phase or prescaler bits
// - output goes low when time base equals buffered duty
// - high time is duty times clock period times prescale
// - resolution reaches ten bits only with limit 255
// - duty beyond period leaves the output unchanged
// - four-bit mode field selects off, compare, capture or pwm
// - alignment bit used only in pwm mode
// - sleep stops period timer and freezes pwm state
`timescale 1ns/1ps
`default_nettype none
module ccpt_channel
  import ccpt_pkg::*;
(
  // clock and reset
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_sys_rst,
  // avalon-mm slave
  input  wire logic [ccpt_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [3:0]                i_avs_byteenable,
  input  wire logic [31:0]               i_avs_writedata,
  output logic [31:0]                    o_avs_readdata,
  output logic                           o_avs_waitrequest,
  // compare time base and system
  input  wire logic [15:0]               i_cmp_timer,
  input  wire logic                      i_cmp_timer_alive,
  input  wire logic                      i_adc_trig_sel,
  input  wire logic                      i_sleep,
  // results
  output logic                           o_channel_output,
  output logic                           o_channel_internal,
  output logic                           o_adc_trig,
  output logic                           o_cmp_timer_clr,
  output logic                           o_wake
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [15:0] duty_q;
  logic [7:0]  plimit_q;
  logic [2:0]  tctrl_q;
  logic [1:0]  flag_q;
  logic        ie_q;
  logic [7:0]  tmr_q;
  logic [9:0]  buf_q;
  logic        out_q;
  logic        pulse_q;
  logic        wait_q;
  logic        wrap_q;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic        req;
  logic        wr_acc;
  logic        wr_ctrl;
  logic        wr_duty;
  logic        wr_plimit;
  logic        wr_tctrl;
  logic        wr_status;
  logic        wr_ie;
  logic [31:0] rd_mux;
  logic [3:0]  mode;
  ccpt_op_t    op;
  logic        en;
  logic        is_pwm;
  logic        is_cmp;
  logic        run;
  logic        tick;
  logic [1:0]  ext;
  logic        wrap;
  logic [9:0]  tb;
  logic [9:0]  duty10;
  logic        cmp_evt;
  logic        cmp_on;
  logic        clears_tmr;
  logic [1:0]  flag_set;
  logic [1:0]  flag_clr;
  logic        out_d;

  assign req       = i_avs_read || i_avs_write;
  // a write takes effect at the edge where waitrequest is seen low
  assign wr_acc    = i_avs_write && !wait_q;
  assign wr_ctrl   = wr_acc && (i_avs_address == REG_CTRL)
                     && i_avs_byteenable[0];
  assign wr_duty   = wr_acc && (i_avs_address == REG_DUTY);
  assign wr_plimit = wr_acc && (i_avs_address == REG_PLIMIT)
                     && i_avs_byteenable[0];
  assign wr_tctrl  = wr_acc && (i_avs_address == REG_TCTRL)
                     && i_avs_byteenable[0];
  assign wr_status = wr_acc && (i_avs_address == REG_STATUS)
                     && i_avs_byteenable[0];
  assign wr_ie     = wr_acc && (i_avs_address == REG_IENABLE)
                     && i_avs_byteenable[0];

  assign mode   = ctrl_q[3:0];
  assign en     = ctrl_q[CTRL_EN_BIT];
  assign op     = en ? ccpt_op_of(mode) : OP_OFF;
  assign is_pwm = (op == OP_PWM);
  assign is_cmp = (op == OP_COMPARE);
  assign clears_tmr = (mode == MODE_TOG_CLR) || (mode == MODE_PULSE_CLR);

  // unmapped words read as zero and ignore writes
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (i_avs_address)
      REG_CTRL:    rd_mux = {24'h00_0000, ctrl_q[7:6], out_q, ctrl_q[4:0]};
      REG_DUTY:    rd_mux = {16'h0000, duty_q};
      REG_PLIMIT:  rd_mux = {24'h00_0000, plimit_q};
      REG_TCTRL:   rd_mux = {29'h0000_0000, tctrl_q};
      REG_STATUS:  rd_mux = {30'h0000_0000, flag_q};
      REG_IENABLE: rd_mux = {31'h0000_0000, ie_q};
      REG_COUNTER: rd_mux = {22'h00_0000, tb};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle, then answer
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      wait_q         <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      wait_q <= !(req && wait_q);
      if (req && wait_q)
        o_avs_readdata <= rd_mux;
    end
  end

  assign o_avs_waitrequest = wait_q;

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < 2; gb++)
    begin : g_duty_lane
      // either byte may change anytime; the pwm sees only the buffer
      always_ff @(posedge i_ref_clk)
      begin
        if (i_sys_rst)
          duty_q[gb*8 +: 8] <= DUTY_RST[gb*8 +: 8];
        else if (wr_duty && i_avs_byteenable[gb])
          duty_q[gb*8 +: 8] <= i_avs_writedata[gb*8 +: 8];
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl_q   <= CTRL_RST;
      plimit_q <= PLIMIT_RST;
      tctrl_q  <= TCTRL_RST;
      ie_q     <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= i_avs_writedata[7:0];
      if (wr_plimit)
        plimit_q <= i_avs_writedata[7:0];
      if (wr_tctrl)
        tctrl_q <= i_avs_writedata[2:0];
      if (wr_ie)
        ie_q <= i_avs_writedata[IE_CMP_BIT];
    end
  end

  // ---------------------------------------------------------------
  // period timer and time base
  // ---------------------------------------------------------------
  // sleep stops the timer; counting resumes from the held state
  assign run = tctrl_q[TCTRL_ON_BIT] && !i_sleep;
  // caller keeps the timer on the instruction clock, so no other source
  ccpt_prescale u_prescale
  (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_run     (run),
    .i_ps_sel  (tctrl_q[TCTRL_PS_LSB +: 2]),
    .o_tick    (tick),
    .o_ext     (ext)
  );
  // no postscaler on this path, so period is limit, clock and prescale
  assign wrap = tick && (tmr_q == plimit_q);
  assign tb   = {tmr_q, ext};
  // left-aligned takes the upper ten bits, right-aligned the lower
  assign duty10 = ctrl_q[CTRL_LEFT_BIT] ? duty_q[15:6]
                                        : duty_q[9:0];

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      tmr_q <= 8'h00;
      buf_q <= 10'h000;
    end
    else if (tick)
    begin
      if (wrap)
      begin
        tmr_q <= 8'h00;
        buf_q <= duty10;
      end
      else
        tmr_q <= tmr_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // compare engine
  // ---------------------------------------------------------------
  // in sleep only an independently clocked timer keeps matching
  assign cmp_on = is_cmp && (!i_sleep || i_cmp_timer_alive);
  ccpt_compare u_compare
  (
    .i_ref_clk      (i_ref_clk),
    .i_sys_rst      (i_sys_rst),
    .i_enable       (cmp_on),
    .i_clears_timer (clears_tmr),
    .i_trig_sel     (i_adc_trig_sel),
    .i_timer        (i_cmp_timer),
    .i_value        (duty_q),
    .o_evt          (cmp_evt),
    .o_adc_trig     (o_adc_trig),
    .o_timer_clr    (o_cmp_timer_clr)
  );

  // ---------------------------------------------------------------
  // output latch
  // ---------------------------------------------------------------
  always_comb
  begin
    out_d = out_q;
    if (wr_ctrl && (i_avs_writedata[7:0] == 8'h00))
      out_d = 1'b0;
    else if (is_pwm && wrap_q)
      out_d = (buf_q != 10'h000);
    else if (is_pwm && (tb == buf_q))
      // duty beyond the period never matches, so the level just holds
      out_d = 1'b0;
    else if (pulse_q)
      out_d = 1'b0;
    else if (cmp_evt)
    begin
      case (mode)
        MODE_TOG_CLR, MODE_TOG:    out_d = !out_q;
        MODE_SET:                  out_d = 1'b1;
        MODE_CLR:                  out_d = 1'b0;
        MODE_PULSE, MODE_PULSE_CLR: out_d = 1'b1;
        default:                   out_d = out_q;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      out_q              <= 1'b0;
      pulse_q            <= 1'b0;
      wrap_q             <= 1'b0;
      o_channel_output   <= 1'b0;
      o_channel_internal <= 1'b0;
    end
    else
    begin
      out_q              <= out_d;
      pulse_q            <= cmp_evt && ((mode == MODE_PULSE)
                            || (mode == MODE_PULSE_CLR));
      wrap_q             <= wrap; // lag keeps high time exact
      o_channel_output   <= out_d;
      o_channel_internal <= out_d;
    end
  end

  // ---------------------------------------------------------------
  // event flags and wake
  // ---------------------------------------------------------------
  assign flag_set = {wrap, cmp_evt || (is_pwm && wrap)};
  assign flag_clr = wr_status ? i_avs_writedata[1:0] : 2'b00;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      flag_q <= 2'b00;
      o_wake <= 1'b0;
    end
    else
    begin
      // a set in the clearing cycle wins
      flag_q <= (flag_q & ~flag_clr) | flag_set;
      o_wake <= i_sleep && ie_q && flag_q[STAT_EVT_BIT];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_zero_ctrl_low: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    wr_ctrl && (i_avs_writedata[7:0] == 8'h00) |=> !o_channel_output)
    else $error("zero control write left output high");
  a_period_wrap: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    wrap |=> (tmr_q == 8'h00) && (buf_q == $past(duty10)))
    else $error("period match did not restart timer and buffer");
  a_pwm_goes_high: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    is_pwm && wrap_q && !wr_ctrl && (buf_q != 10'h000)
      |=> o_channel_output)
    else $error("pwm output not set at period start");
  a_pwm_match_low: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    is_pwm && !wrap_q && (tb == buf_q) |=> !o_channel_output)
    else $error("pwm output not cleared at duty match");
  a_sleep_freeze: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_sleep |=> $stable(tmr_q) && $stable(buf_q))
    else $error("period timer moved during sleep");
  a_flag_set_wins: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    cmp_evt |=> flag_q[STAT_EVT_BIT])
    else $error("compare event flag not set");
  a_bus_answer: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    req && wait_q |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one wait cycle");
  a_internal_copy: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    o_channel_internal == o_channel_output)
    else $error("internal copy differs from channel output");

endmodule
`default_nettype wire

// >>> ccpt_load_model.sv
// load model on the channel pin: measures period and high time
`timescale 1ns/1ps
`default_nettype none
module ccpt_load_model
(
  // clock and pin
  input  wire logic        i_ref_clk,
  input  wire logic        i_pin,
  // measurements
  output logic [15:0]      o_period,
  output logic [15:0]      o_high,
  output logic [15:0]      o_rises
);
  // ---------------------------------------------------------------
  // edge timing, sampled on the system clock
  // ---------------------------------------------------------------
  logic        last_q;
  logic [15:0] cnt_q;
  initial
  begin
    last_q   = 1'b0;
    cnt_q    = 16'h0000;
    o_period = 16'h0000;
    o_high   = 16'h0000;
    o_rises  = 16'h0000;
  end
  // a pure load: it only listens, so it cannot disturb the channel
  always @(posedge i_ref_clk)
  begin
    last_q <= i_pin;
    cnt_q  <= cnt_q + 16'h0001;
    if (i_pin === 1'b1 && last_q === 1'b0)
    begin
      o_period <= cnt_q + 16'h0001;
      o_rises  <= o_rises + 16'h0001;
      cnt_q    <= 16'h0000;
    end
    if (i_pin === 1'b0 && last_q === 1'b1)
      o_high <= cnt_q + 16'h0001;
  end
endmodule
`default_nettype wire

// >>> ccpt_channel_tb.sv
// self-checking testbench for the compare tail and pwm channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module ccpt_channel_tb;
  import ccpt_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  av_a = 3'h0;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [31:0] av_wd = 32'h0;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic [15:0] cmp_t = 16'h0000;
  logic        alive = 1'b0;
  logic        trig_sel = 1'b1;
  logic        sleep = 1'b0;
  logic        pin, pin_int, adc_trig, tmr_clr, wake;
  logic [15:0] per, hi, rises, r0;
  logic [31:0] rd;
  int          bad_count = 0;
  int          checked = 0;
  int          trig_cnt = 0;
  int          clr_cnt = 0;
  always #2 clk = ~clk;
  ccpt_channel u_ccpt_channel (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_avs_address(av_a),
    .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_byteenable(4'hF),
    .i_avs_writedata(av_wd), .o_avs_readdata(av_rdata),
    .o_avs_waitrequest(av_wait), .i_cmp_timer(cmp_t),
    .i_cmp_timer_alive(alive), .i_adc_trig_sel(trig_sel),
    .i_sleep(sleep), .o_channel_output(pin), .o_channel_internal(pin_int),
    .o_adc_trig(adc_trig), .o_cmp_timer_clr(tmr_clr), .o_wake(wake));
  ccpt_load_model u_ccpt_load_model (
    .i_ref_clk(clk), .i_pin(pin), .o_period(per), .o_high(hi),
    .o_rises(rises));
  always @(posedge clk)
  begin
    if (adc_trig === 1'b1) trig_cnt++;
    if (tmr_clr === 1'b1) clr_cnt++;
  end
  // ---------------------------------------------------------------
  // avalon tasks: hold request until waitrequest is sampled low
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    av_a  <= a;
    av_wd <= d;
    av_wr <= w;
    av_rd <= ~w;
    @(posedge clk);
    while (av_wait !== 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    rd = av_rdata;
    if (n >= 100) `CHK("waitrequest", 1'b0, av_wait)
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    // an edge passes so the next request never lands in this time step
    @(posedge clk);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [31:0] m,
                      input logic [31:0] ex, input string nm);
    bus(1'b0, a, 32'h0);
    `CHK(nm, ex, rd & m)
  endtask
  // pwm run: limit, prescale code, control, duty; then measure
  task automatic pwm(input logic [7:0] lim, input logic [1:0] ps,
                     input logic [7:0] ctl, input logic [15:0] duty);
    bus(1'b1, REG_PLIMIT, {24'h0, lim});
    bus(1'b1, REG_CTRL, {24'h0, ctl});
    bus(1'b1, REG_DUTY, {16'h0, duty});
    bus(1'b1, REG_STATUS, 32'h3);
    bus(1'b1, REG_TCTRL, {29'h0, ps, 1'b1});
    repeat (3 * (lim + 1) * INSTR_DIV * (1 << (2 * ps)) + 8) @(posedge clk);
  endtask
  task automatic ramp();
    for (int i = 0; i < 32; i++)
    begin
      cmp_t <= 16'(i);
      @(posedge clk);
      if (i == 16) repeat (3) @(posedge clk);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #(60000 * 4);
    bad_count++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("pin reset", 1'b0, pin)
    rchk(REG_CTRL, 32'hFF, 32'h00, "ctrl reset");
    rchk(REG_DUTY, 32'hFFFF, 32'h0000, "duty reset");
    rchk(REG_PLIMIT, 32'hFF, 32'hFF, "limit reset");
    rchk(REG_TCTRL, 32'h7, 32'h0, "tctrl reset");
    rchk(REG_COUNTER, 32'h3FF, 32'h0, "counter reset");
    bus(1'b1, 3'h7, 32'hFFFF_FFFF);
    rchk(3'h7, 32'hFFFF_FFFF, 32'h0, "unmapped");
    // right aligned, 1:1: period and high time in clocks
    pwm(8'h03, 2'h0, 8'h8C, 16'h0006);
    `CHK("period 1:1", 16'(4 * INSTR_DIV), per)
    `CHK("high 1:1", 16'h0006, hi)
    `CHK("internal copy", pin, pin_int)
    // left aligned: duty taken from bits 15:6
    bus(1'b1, REG_CTRL, 32'h9C);
    bus(1'b1, REG_DUTY, 32'h0280);
    repeat (40) @(posedge clk);
    `CHK("high left", 16'h000A, hi)
    // prescale 1:4 stretches both period and high time
    pwm(8'h03, 2'h1, 8'h8C, 16'h0005);
    `CHK("period 1:4", 16'(4 * INSTR_DIV * 4), per)
    `CHK("high 1:4", 16'h0014, hi)
    // sleep freezes the time base and the pin; enabled event wakes
    bus(1'b1, REG_IENABLE, 32'h1);
    sleep <= 1'b1;
    repeat (2) @(posedge clk); // a wrap already in flight lands first
    r0 = {15'h0, pin};
    bus(1'b0, REG_COUNTER, 32'h0);
    r0[15:6] = rd[9:0];
    repeat (30) @(posedge clk);
    `CHK("pin frozen", r0[0], pin)
    rchk(REG_COUNTER, 32'h3FF, {22'h0, r0[15:6]}, "counter frozen");
    `CHK("wake", 1'b1, wake)
    sleep <= 1'b0;
    bus(1'b1, REG_IENABLE, 32'h0);
    `CHK("wake off", 1'b0, wake)
    // duty above the period: pin stays high
    pwm(8'h03, 2'h0, 8'h8C, 16'h0030);
    `CHK("over duty", 1'b1, pin)
    // zero duty: no rising edge at period match
    pwm(8'h03, 2'h0, 8'h8C, 16'h0000);
    r0 = rises;
    repeat (64) @(posedge clk);
    `CHK("zero duty", r0, rises)
    // limit 255 gives the full ten-bit time base
    pwm(8'hFF, 2'h0, 8'h8C, 16'h03FF);
    `CHK("period 10b", 16'h0400, per)
    `CHK("high 10b", 16'h03FF, hi)
    bus(1'b1, REG_TCTRL, 32'h0);
    // compare set then clear-by-zero write
    bus(1'b1, REG_CTRL, 32'h00);
    bus(1'b1, REG_STATUS, 32'h3);
    bus(1'b1, REG_DUTY, 32'h0010);
    bus(1'b1, REG_CTRL, {24'h0, 4'h8, MODE_SET});
    trig_cnt = 0;
    clr_cnt = 0;
    ramp();
    `CHK("set out", 1'b1, pin)
    `CHK("adc trig", 1, trig_cnt)
    rchk(REG_STATUS, 32'h1, 32'h1, "event flag");
    bus(1'b1, REG_CTRL, 32'h00);
    @(posedge clk);
    `CHK("ctrl zero", 1'b0, pin)
    // toggle and clear timer: match held, so one clear request
    bus(1'b1, REG_CTRL, {24'h0, 4'h8, MODE_TOG_CLR});
    ramp();
    `CHK("toggle out", 1'b1, pin)
    `CHK("timer clear", 1, clr_cnt)
    // pulse-and-clear with the match removed at once: no clear
    bus(1'b1, REG_CTRL, 32'h00);
    bus(1'b1, REG_CTRL, {24'h0, 4'h8, MODE_PULSE_CLR});
    clr_cnt = 0;
    for (int i = 14; i < 18; i++)
    begin
      cmp_t <= 16'(i);
      @(posedge clk);
    end
    `CHK("pulse high", 1'b1, pin)
    repeat (2) @(posedge clk);
    `CHK("no clear", 0, clr_cnt)
    `CHK("pulse over", 1'b0, pin)
    complete_run();
  end
endmodule
`default_nettype wire
